// ### include/cbt_pkg.sv
// Functional notes
// [RULE1] answer only at the one selected address
// [RULE2] accept both block write and block read
// [RULE3] two pointer bytes follow a write address
// [RULE4] pointer steps up per byte, msb first
// [RULE5] stop after any whole byte, drop partials
// [RULE6] stage writes, commit all together at stop
// [RULE7] address 0xD4 unless select bit picks 0xD0
// [RULE8] no acknowledge while save or restore runs
// [RULE9] read resumes at pointer left by write
package cbt_pkg;

	// target addresses, 8-bit form with the direction bit at zero
	localparam logic [7:0]  CBT_ADDR_DEFAULT    = 8'hD4;
	localparam logic [7:0]  CBT_ADDR_ALT        = 8'hD0;

	// register holding the save / restore command bits
	localparam logic [15:0] CBT_NVM_CMD_REG     = 16'h0072;
	localparam int          CBT_NVM_SAVE_BIT    = 3;
	localparam int          CBT_NVM_RESTORE_BIT = 0;

	// bit positions inside one nine-clock byte slot
	localparam logic [3:0]  CBT_LAST_BIT        = 4'h7;
	localparam logic [3:0]  CBT_ACK_SLOT        = 4'h8;

	// sizes and reset values
	localparam int          CBT_REG_COUNT       = 128;
	localparam int          CBT_BUF_DEPTH       = 2;
	localparam logic [7:0]  CBT_CFG_RESET       = 8'h00;
	localparam logic [15:0] CBT_PTR_RESET       = 16'h0000;

	// transfer engine states
	typedef enum logic [2:0] {
		CBT_IDLE,
		CBT_ADDR,
		CBT_REG_HI,
		CBT_REG_LO,
		CBT_WDATA,
		CBT_RDATA,
		CBT_IGNORE,
		CBT_BUSY
	} cbt_state_e;

	// word handed from the link clock to the system clock
	typedef struct packed {
		logic       is_ack;
		logic [7:0] data;
	} cbt_link_word_s;

endpackage

// ### src/cbt_i2c_target.sv
`timescale 1ns/100ps
module cbt_i2c_target
	import cbt_pkg::*;
#(
	parameter int REG_COUNT = CBT_REG_COUNT,
	parameter int BUF_DEPTH = CBT_BUF_DEPTH
)
(
	// system clock and reset
	input  wire logic                         clk_sys_i,
	input  wire logic                         reset_n_i,
	// serial bus pins
	input  wire logic                         scl_i,
	input  wire logic                         sda_i,
	output      logic                         sda_o,
	output      logic                         sda_oe_o,
	// configuration strap and register read port
	input  wire logic                         addr_sel_i,
	input  wire logic [$clog2(REG_COUNT)-1:0] cfg_rd_idx_i,
	output      logic [7:0]                   cfg_rd_data_o,
	output      logic                         commit_o,
	// nonvolatile save / restore handshake
	output      logic                         nvm_save_o,
	output      logic                         nvm_restore_o,
	input  wire logic                         nvm_done_i,
	output      logic                         busy_o
);
	localparam int IDX_W  = $clog2(REG_COUNT);
	localparam int BPTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

	// register index from a 16-bit pointer, upper bits wrap
	function automatic logic [IDX_W-1:0] idx_of(input logic [15:0] ptr);
		idx_of = ptr[IDX_W-1:0];
	endfunction

	// circular step of a buffer pointer
	function automatic logic [BPTR_W-1:0] bump(input logic [BPTR_W-1:0] p);
		bump = (p == BPTR_W'(BUF_DEPTH - 1)) ? '0 : p + BPTR_W'(1);
	endfunction

	// ---------------- link clock domain ----------------
	logic           link_clr_q;  // held from start until scl falls
	logic [3:0]     bit_cnt_q;   // 0..7 data bits, 8 acknowledge slot
	logic [7:0]     shift_q;     // incoming bits, msb first
	cbt_link_word_s lword_q;     // last finished byte or ack bit
	logic           ltgl_q;      // flips once per published word
	logic           sda_oe_q;    // pin drive, changes on scl low
	logic           ack_en_q;    // system side: drive ack slot
	logic           tx_en_q;     // system side: shift out tx byte
	logic [7:0]     tx_byte_q;   // system side: byte being read out

	wire            link_rst_n = reset_n_i & ~link_clr_q;
	wire [7:0]      shift_next = {shift_q[6:0], sda_i};
	wire [3:0]      cnt_next   = (bit_cnt_q == CBT_ACK_SLOT) ? 4'h0 : bit_cnt_q + 4'h1;
	wire            at_ack     = bit_cnt_q == CBT_ACK_SLOT;
	wire            oe_next    = at_ack ? ack_en_q : (tx_en_q & ~tx_byte_q[~bit_cnt_q[2:0]]);

	// bit counter and shifter, cleared at every start so no partial byte survives
	always_ff @(posedge scl_i or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			bit_cnt_q <= 4'h0;
			shift_q   <= 8'h00;
		end
		else
		begin
			bit_cnt_q <= cnt_next;    // [RULE5]
			shift_q   <= shift_next;  // [RULE4]
		end
	end

	// publish words; toggle reset only by system reset to avoid false events
	always_ff @(posedge scl_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			lword_q <= '0;
			ltgl_q  <= 1'b0;
		end
		else if (link_rst_n && (bit_cnt_q == CBT_LAST_BIT || at_ack))
		begin
			lword_q <= at_ack ? cbt_link_word_s'{1'b1, {7'h00, sda_i}} : cbt_link_word_s'{1'b0, shift_next};
			ltgl_q  <= ~ltgl_q;
		end
	end

	// data and ack drive change only while scl is low
	always_ff @(negedge scl_i or negedge link_rst_n)
	begin
		if (!link_rst_n)
			sda_oe_q <= 1'b0;
		else
			sda_oe_q <= oe_next;  // [RULE4]
	end

	assign sda_o    = 1'b0;
	assign sda_oe_o = sda_oe_q;

	// ---------------- system clock domain ----------------
	logic [1:0] scl_sync_q;  // two-stage synchroniser
	logic [1:0] sda_sync_q;  // two-stage synchroniser
	logic       scl_d_q;     // delayed copy for edge detect
	logic       sda_d_q;     // delayed copy for edge detect
	logic [1:0] tgl_sync_q;  // word toggle synchroniser
	logic       tgl_d_q;     // last toggle accepted

	wire scl_s     = scl_sync_q[1];
	wire sda_s     = sda_sync_q[1];
	wire start_det = scl_s & scl_d_q & sda_d_q & ~sda_s;
	wire stop_det  = scl_s & scl_d_q & ~sda_d_q & sda_s;
	wire scl_fall  = scl_d_q & ~scl_s;
	wire bus_edge  = start_det | stop_det;
	wire evt       = tgl_sync_q[1] ^ tgl_d_q;
	logic buf_in_ready;

	// pin and toggle synchronisers; toggle waits while the buffer is full
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_d_q    <= 1'b1;
			sda_d_q    <= 1'b1;
			tgl_sync_q <= 2'h0;
			tgl_d_q    <= 1'b0;
		end
		else
		begin
			scl_sync_q <= {scl_sync_q[0], scl_i};
			sda_sync_q <= {sda_sync_q[0], sda_i};
			scl_d_q    <= scl_s;
			sda_d_q    <= sda_s;
			tgl_sync_q <= {tgl_sync_q[0], ltgl_q};
			tgl_d_q    <= buf_in_ready ? tgl_sync_q[1] : tgl_d_q;
		end
	end

	// holds the link logic in reset from start until scl goes low
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			link_clr_q <= 1'b0;
		else if (start_det)
			link_clr_q <= 1'b1;  // [RULE5]
		else if (scl_fall)
			link_clr_q <= 1'b0;
	end

	// two-entry word buffer between crossing and transfer engine
	cbt_link_word_s    buf_mem_q [BUF_DEPTH];
	logic [BPTR_W-1:0] wr_ptr_q;
	logic [BPTR_W-1:0] rd_ptr_q;
	logic [BPTR_W:0]   count_q;

	assign buf_in_ready = count_q != (BPTR_W+1)'(BUF_DEPTH);
	wire                buf_out_valid = count_q != '0;
	wire                buf_out_ready = ~bus_edge;
	wire                push          = evt & buf_in_ready;
	wire                pop           = buf_out_valid & buf_out_ready;
	wire cbt_link_word_s buf_head     = buf_mem_q[rd_ptr_q];

	// buffer storage and pointers
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			for (int i = 0; i < BUF_DEPTH; i++)
				buf_mem_q[i] <= '0;
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end
		else
		begin
			if (push)
				buf_mem_q[wr_ptr_q] <= lword_q;
			wr_ptr_q <= push ? bump(wr_ptr_q) : wr_ptr_q;
			rd_ptr_q <= pop ? bump(rd_ptr_q) : rd_ptr_q;
			count_q  <= count_q + (BPTR_W+1)'(push) - (BPTR_W+1)'(pop);
		end
	end

	// transfer engine
	cbt_state_e       state_q;
	cbt_state_e       state_d;
	logic [15:0]      ptr_q;                   // register pointer
	logic [7:0]       cfg_q [REG_COUNT];       // live configuration registers
	logic [7:0]       stage_q [REG_COUNT];     // write staging bytes
	logic [REG_COUNT-1:0] stage_vld_q;         // staged byte present
	logic             commit_q;
	logic             nvm_save_q;
	logic             nvm_restore_q;
	logic [7:0]       cfg_rd_data_q;

	wire [7:0]       my_addr   = addr_sel_i ? CBT_ADDR_ALT : CBT_ADDR_DEFAULT;  // [RULE7]
	wire             pop_data  = pop & ~buf_head.is_ack;
	wire             pop_ack   = pop & buf_head.is_ack;
	wire             addr_hit  = buf_head.data[7:1] == my_addr[7:1];            // [RULE1]
	wire             is_read   = buf_head.data[0];
	wire             take_addr = pop_data & (state_q == CBT_ADDR);
	wire             take_hi   = pop_data & (state_q == CBT_REG_HI);
	wire             take_lo   = pop_data & (state_q == CBT_REG_LO);
	wire             take_wr   = pop_data & (state_q == CBT_WDATA);
	wire             take_rd   = pop_data & (state_q == CBT_RDATA);
	wire             hit_read  = take_addr & addr_hit & is_read;
	wire             nack_rd   = pop_ack & (state_q == CBT_RDATA) & buf_head.data[0];
	wire [15:0]      ptr_inc   = ptr_q + 16'h0001;
	wire [7:0]       rd_byte   = cfg_q[idx_of(ptr_q)];
	wire [7:0]       nxt_byte  = cfg_q[idx_of(ptr_inc)];
	wire [IDX_W-1:0] nvm_idx   = idx_of(CBT_NVM_CMD_REG);
	wire [7:0]       nvm_byte  = stage_q[nvm_idx];
	wire             nvm_go    = stop_det & stage_vld_q[nvm_idx] &
	                             (nvm_byte[CBT_NVM_SAVE_BIT] | nvm_byte[CBT_NVM_RESTORE_BIT]);
	wire             nvm_end   = (state_q == CBT_BUSY) & nvm_done_i;

	// next-value selection for the engine registers
	wire        ack_any  = (take_addr & addr_hit) | take_hi | take_lo | take_wr;
	wire        ack_en_d = (bus_edge | pop_ack) ? 1'b0 : (pop_data ? ack_any : ack_en_q);
	wire        tx_en_d  = (bus_edge | nack_rd) ? 1'b0 : (hit_read | tx_en_q);
	wire [7:0]  tx_byte_d = hit_read ? rd_byte : (take_rd ? nxt_byte : tx_byte_q);
	wire [15:0] ptr_d    = take_hi ? {buf_head.data, ptr_q[7:0]} :
	                       take_lo ? {ptr_q[15:8], buf_head.data} :
	                       (take_wr | take_rd) ? ptr_inc : ptr_q;

	// state sequencing; busy absorbs starts so nothing is acknowledged
	always_comb
	begin
		state_d = state_q;
		if (stop_det)
			state_d = (nvm_go || state_q == CBT_BUSY) ? CBT_BUSY : CBT_IDLE;  // [RULE8]
		else if (state_q == CBT_BUSY)
			state_d = nvm_done_i ? CBT_IDLE : CBT_BUSY;
		else if (start_det)
			state_d = CBT_ADDR;
		else if (pop_data)
		begin
			unique case (state_q)
				CBT_ADDR:   state_d = !addr_hit ? CBT_IGNORE : (is_read ? CBT_RDATA : CBT_REG_HI);  // [RULE2]
				CBT_REG_HI: state_d = CBT_REG_LO;   // [RULE3]
				CBT_REG_LO: state_d = CBT_WDATA;
				CBT_IDLE, CBT_WDATA, CBT_RDATA, CBT_IGNORE, CBT_BUSY: state_d = state_q;
			endcase
		end
		else if (nack_rd)
			state_d = CBT_IGNORE;
	end

	// engine registers
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_q   <= CBT_IDLE;
			ptr_q     <= CBT_PTR_RESET;
			ack_en_q  <= 1'b0;
			tx_en_q   <= 1'b0;
			tx_byte_q <= 8'h00;
		end
		else
		begin
			state_q   <= state_d;
			ptr_q     <= ptr_d;      // [RULE3] [RULE4] [RULE9]
			ack_en_q  <= ack_en_d;   // [RULE1] [RULE8]
			tx_en_q   <= tx_en_d;
			tx_byte_q <= tx_byte_d;  // [RULE9]
		end
	end

	// staging buffer; every staged byte lands in one cycle at stop
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			for (int i = 0; i < REG_COUNT; i++)
			begin
				stage_q[i] <= CBT_CFG_RESET;
				cfg_q[i]   <= CBT_CFG_RESET;
			end
			stage_vld_q <= '0;
		end
		else
		begin
			if (take_wr)
			begin
				stage_q[idx_of(ptr_q)]     <= buf_head.data;  // [RULE6]
				stage_vld_q[idx_of(ptr_q)] <= 1'b1;
			end
			if (stop_det)
			begin
				for (int i = 0; i < REG_COUNT; i++)
					if (stage_vld_q[i])
						cfg_q[i] <= stage_q[i];  // [RULE6]
				stage_vld_q <= '0;
			end
		end
	end

	// commit strobe, save / restore requests and register read port
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			commit_q      <= 1'b0;
			nvm_save_q    <= 1'b0;
			nvm_restore_q <= 1'b0;
			cfg_rd_data_q <= CBT_CFG_RESET;
		end
		else
		begin
			commit_q      <= stop_det & (|stage_vld_q);
			nvm_save_q    <= (nvm_go & nvm_byte[CBT_NVM_SAVE_BIT]) | (nvm_save_q & ~nvm_end);
			nvm_restore_q <= (nvm_go & nvm_byte[CBT_NVM_RESTORE_BIT]) | (nvm_restore_q & ~nvm_end);
			cfg_rd_data_q <= cfg_q[cfg_rd_idx_i];
		end
	end

	assign commit_o      = commit_q;
	assign nvm_save_o    = nvm_save_q;
	assign nvm_restore_o = nvm_restore_q;
	assign cfg_rd_data_o = cfg_rd_data_q;
	assign busy_o        = state_q == CBT_BUSY;

	// ---------------- checks ----------------
	addr_miss_a: assert property (  // [RULE1]
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		take_addr && !addr_hit |=> !ack_en_q && state_q == CBT_IGNORE)
		else $error("foreign address was answered");
	addr_select_a: assert property (  // [RULE7]
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		take_addr && !is_read && !addr_sel_i && buf_head.data[7:1] == CBT_ADDR_DEFAULT[7:1]
		|=> ack_en_q && state_q == CBT_REG_HI)
		else $error("default address not taken");
	read_accept_a: assert property (  // [RULE2]
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		hit_read |=> tx_en_q && ack_en_q && state_q == CBT_RDATA)
		else $error("block read not started");
	ptr_load_a: assert property (  // [RULE3]
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		take_lo |=> ptr_q[7:0] == $past(buf_head.data) && state_q == CBT_WDATA)
		else $error("pointer low byte not loaded");
	ptr_step_a: assert property (  // [RULE4]
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		take_wr || take_rd |=> ptr_q == $past(ptr_q) + 16'h0001)
		else $error("pointer did not advance by one");
	bit_wrap_a: assert property (  // [RULE4]
		@(posedge scl_i) disable iff (!link_rst_n)
		bit_cnt_q == CBT_ACK_SLOT |=> bit_cnt_q == 4'h0)
		else $error("bit counter passed the ack slot");
	stop_clean_a: assert property (  // [RULE5]
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		stop_det |=> !ack_en_q && !tx_en_q && (state_q == CBT_IDLE || state_q == CBT_BUSY) ##1 !ack_en_q)
		else $error("transfer state left after stop");
	commit_stop_a: assert property (  // [RULE6]
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		commit_q |-> $past(stop_det) && stage_vld_q == '0)
		else $error("commit without stop");
	busy_silent_a: assert property (  // [RULE8]
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		nvm_go |=> state_q == CBT_BUSY && !ack_en_q && (nvm_save_q || nvm_restore_q))
		else $error("save or restore did not hold the bus");
	busy_noack_a: assert property (  // [RULE8]
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		state_q == CBT_BUSY |-> !ack_en_q && !tx_en_q)
		else $error("acknowledge while busy");
	read_resume_a: assert property (  // [RULE9]
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		hit_read |=> tx_byte_q == $past(rd_byte))
		else $error("read not taken from pointer");

	write_commit_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) take_wr ##[1:1000] commit_q);
	read_burst_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) take_rd ##[1:1000] take_rd);
	nvm_done_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) nvm_go ##[1:1000] nvm_end);
	buf_full_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) !buf_in_ready);

endmodule

// ### bench/cbt_i2c_ctrl_model.sv
`timescale 1ns/100ps
// bus controller model: drives scl and pulls sda low, paced by the system clock
module cbt_i2c_ctrl_model
(
	// pacing clock
	input  wire logic clk_sys_i,
	// resolved data wire, pulled up
	input  wire logic sda_i,
	// bus clock and data pull-down
	output      logic scl_o,
	output      logic sda_low_o
);
	localparam int HALF  = 50; // scl high phase and data-to-edge time, 1 us
	localparam int SETUP = 25; // data change after scl fell; low phase 1.5 us, period 2.5 us

	// scl stands high and sda released between frames
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// wait whole system cycles so every change lands on a rising edge
	task automatic wait_c(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	// start or repeated start: sda falls while scl is high
	task automatic start_c();
		wait_c(SETUP);
		sda_low_o <= 1'b0;
		wait_c(HALF);
		scl_o <= 1'b1;
		wait_c(HALF);
		sda_low_o <= 1'b1;
		wait_c(HALF);
		scl_o <= 1'b0;
	endtask

	// stop: sda rises while scl is high, then bus free time
	task automatic stop_c();
		wait_c(SETUP);
		sda_low_o <= 1'b1;
		wait_c(HALF);
		scl_o <= 1'b1;
		wait_c(HALF);
		sda_low_o <= 1'b0;
		wait_c(2 * HALF);
	endtask

	// one clock: data set well after scl fell, sampled at end of high phase
	task automatic bit_io(input logic b, output logic s);
		wait_c(SETUP);
		sda_low_o <= ~b;
		wait_c(HALF);
		scl_o <= 1'b1;
		wait_c(HALF);
		s = sda_i;
		scl_o <= 1'b0;
	endtask

	// whole byte out, msb first, then the acknowledge slot
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask

	// whole byte in, then acknowledge or, on the last one, not
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, s);
	endtask
endmodule

// ### bench/cbt_i2c_target_bench.sv
`timescale 1ns/100ps
module cbt_i2c_target_bench;
	import cbt_pkg::*;
	logic       clk_sys_i;   // system clock
	logic       reset_n_i;   // reset, active low
	logic       scl_w;       // bus clock from controller
	logic       m_low;       // controller pulls data low
	logic       addr_sel;    // address select strap
	logic       nvm_done;    // save / restore finished
	logic [6:0] rd_idx;      // register read index
	logic [7:0] rd_data;     // register read data
	logic       sda_o_w;     // constant low drive level
	logic       sda_oe;      // device pulls data low
	logic       commit;      // commit pulse
	logic       save;        // save requested
	logic       restore;     // restore requested
	logic       busy;        // save / restore running
	wire        sda_w = ~(m_low | sda_oe); // pull-up unless someone pulls low
	int         failures = 0;
	int         comparisons = 0;
	int         commits = 0;

	cbt_i2c_target cbt_i2c_target_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .scl_i(scl_w),
		.sda_i(sda_w), .sda_o(sda_o_w), .sda_oe_o(sda_oe), .addr_sel_i(addr_sel), .cfg_rd_idx_i(rd_idx),
		.cfg_rd_data_o(rd_data), .commit_o(commit), .nvm_save_o(save), .nvm_restore_o(restore),
		.nvm_done_i(nvm_done), .busy_o(busy));
	cbt_i2c_ctrl_model cbt_i2c_ctrl_model_i (.clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl_w),
		.sda_low_o(m_low));

	// 50 MHz system clock
	initial
	begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	// count commit pulses, one per committing stop
	always @(posedge clk_sys_i)
		if (commit === 1'b1)
			commits <= commits + 1;

	task automatic final_report();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// read a configuration register through the system port
	task automatic rd_cfg(input logic [6:0] idx, output logic [7:0] d);
		@(posedge clk_sys_i);
		rd_idx <= idx;
		repeat (2) @(posedge clk_sys_i);
		#1 d = rd_data;
	endtask

	// bounded wait for exactly one new commit pulse
	task automatic wait_commit(input int n0);
		for (int i = 0; i < 40 && commits == n0; i++)
			@(posedge clk_sys_i);
		repeat (3) @(posedge clk_sys_i);
		chk8(8'(commits - n0), 8'h01, "commit pulse count");
	endtask

	// bounded wait for busy to reach a level
	task automatic wait_busy(input logic lvl);
		for (int i = 0; i < 40 && busy !== lvl; i++)
			@(posedge clk_sys_i);
		#1;
		chk8({7'h00, busy}, {7'h00, lvl}, "busy level");
		if (busy !== lvl)
			final_report();
	endtask

	// start, address, two pointer bytes, each acknowledged
	task automatic xfer_ptr(input logic [7:0] adr, input logic [15:0] ptr);
		logic ack;
		cbt_i2c_ctrl_model_i.start_c();
		cbt_i2c_ctrl_model_i.wr_byte(adr, ack);
		chk8({7'h00, ack}, 8'h01, "address ack");
		cbt_i2c_ctrl_model_i.wr_byte(ptr[15:8], ack);
		chk8({7'h00, ack}, 8'h01, "pointer hi ack");
		cbt_i2c_ctrl_model_i.wr_byte(ptr[7:0], ack);
		chk8({7'h00, ack}, 8'h01, "pointer lo ack");
	endtask

	// block write: first byte not visible until stop, then both bytes at once
	task automatic t_write();
		logic ack;
		logic [7:0] d;
		int n0;
		xfer_ptr(CBT_ADDR_DEFAULT, 16'h0005);
		cbt_i2c_ctrl_model_i.wr_byte(8'hA5, ack);
		cbt_i2c_ctrl_model_i.wr_byte(8'h3C, ack);
		chk8({7'h00, ack}, 8'h01, "data ack");
		rd_cfg(7'h05, d);
		chk8(d, 8'h00, "staged byte visible early");
		n0 = commits;
		cbt_i2c_ctrl_model_i.stop_c();
		wait_commit(n0);
		rd_cfg(7'h05, d);
		chk8(d, 8'hA5, "first byte");
		rd_cfg(7'h06, d);
		chk8(d, 8'h3C, "second byte");
		$display("test write done");
	endtask

	// each strap setting answers only its own address
	task automatic t_addr();
		logic ack;
		logic [7:0] a;
		for (int s = 0; s < 2; s++)
		begin
			@(posedge clk_sys_i);
			addr_sel <= s[0];
			for (int k = 0; k < 2; k++)
			begin
				a = k ? CBT_ADDR_DEFAULT : CBT_ADDR_ALT;
				cbt_i2c_ctrl_model_i.start_c();
				cbt_i2c_ctrl_model_i.wr_byte(a, ack);
				chk8({7'h00, ack}, {7'h00, (a == (s ? CBT_ADDR_ALT : CBT_ADDR_DEFAULT))}, "select");
				cbt_i2c_ctrl_model_i.stop_c();
			end
		end
		@(posedge clk_sys_i);
		addr_sel <= 1'b0;
		$display("test address done");
	endtask

	// combined read: pointer set by a write, repeated start, read two
	task automatic t_read();
		logic ack;
		logic [7:0] d;
		xfer_ptr(CBT_ADDR_DEFAULT, 16'h0005);
		cbt_i2c_ctrl_model_i.start_c();
		cbt_i2c_ctrl_model_i.wr_byte(CBT_ADDR_DEFAULT | 8'h01, ack);
		chk8({7'h00, ack}, 8'h01, "read address ack");
		cbt_i2c_ctrl_model_i.rd_byte(1'b0, d);
		chk8(d, 8'hA5, "read first");
		cbt_i2c_ctrl_model_i.rd_byte(1'b1, d);
		chk8(d, 8'h3C, "read second");
		chk8({7'h00, sda_o_w}, 8'h00, "open drain level");
		cbt_i2c_ctrl_model_i.stop_c();
		$display("test read done");
	endtask

	// stop after three bits of a second byte: partial byte dropped
	task automatic t_early();
		logic ack;
		logic s;
		logic [7:0] d;
		int n0;
		xfer_ptr(CBT_ADDR_DEFAULT, 16'h0010);
		cbt_i2c_ctrl_model_i.wr_byte(8'h77, ack);
		cbt_i2c_ctrl_model_i.bit_io(1'b1, s);
		cbt_i2c_ctrl_model_i.bit_io(1'b0, s);
		cbt_i2c_ctrl_model_i.bit_io(1'b1, s);
		n0 = commits;
		cbt_i2c_ctrl_model_i.stop_c();
		wait_commit(n0);
		rd_cfg(7'h10, d);
		chk8(d, 8'h77, "whole byte kept");
		rd_cfg(7'h11, d);
		chk8(d, 8'h00, "partial byte dropped");
		$display("test early stop done");
	endtask

	// save then restore: no acknowledge while busy, back after done
	task automatic t_nvm();
		logic ack;
		for (int k = 0; k < 2; k++)
		begin
			xfer_ptr(CBT_ADDR_DEFAULT, CBT_NVM_CMD_REG);
			cbt_i2c_ctrl_model_i.wr_byte(k ? 8'h01 : 8'h08, ack);
			cbt_i2c_ctrl_model_i.stop_c();
			wait_busy(1'b1);
			chk8({7'h00, save}, {7'h00, k == 0}, "save request");
			chk8({7'h00, restore}, {7'h00, k == 1}, "restore request");
			cbt_i2c_ctrl_model_i.start_c();
			cbt_i2c_ctrl_model_i.wr_byte(CBT_ADDR_DEFAULT, ack);
			chk8({7'h00, ack}, 8'h00, "ack while busy");
			cbt_i2c_ctrl_model_i.stop_c();
			@(posedge clk_sys_i);
			nvm_done <= 1'b1;
			@(posedge clk_sys_i);
			nvm_done <= 1'b0;
			wait_busy(1'b0);
			cbt_i2c_ctrl_model_i.start_c();
			cbt_i2c_ctrl_model_i.wr_byte(CBT_ADDR_DEFAULT, ack);
			chk8({7'h00, ack}, 8'h01, "ack after done");
			cbt_i2c_ctrl_model_i.stop_c();
		end
		$display("test save restore done");
	endtask

	// reset, then the scenarios in order
	initial
	begin
		reset_n_i = 1'b0;
		addr_sel = 1'b0;
		nvm_done = 1'b0;
		rd_idx = 7'h00;
		repeat (10) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		t_write();
		t_addr();
		t_read();
		t_early();
		t_nvm();
		final_report();
	end
endmodule
